/* verilog/ioxap_pkg.sv */
package ioxap_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_ACCESS   = 12'h430;
  localparam logic [11:0] OFS_EXPADDR0 = 12'h434;
  localparam logic [11:0] OFS_EXPADDR1 = 12'h438;
  localparam logic [11:0] OFS_INT_STAT = 12'h440;
  localparam logic [11:0] OFS_INT_CLR  = 12'h444;
  localparam logic [11:0] OFS_INT_EN   = 12'h448;
  // Access register fields
  localparam int          PIN_W        = 16;
  localparam int          REFRESH_BIT  = 24;
  localparam int          TEST_BIT     = 25;
  localparam int          SEL_LSB      = 26;
  localparam int          SEL_W        = 4;
  localparam int          DONE_BIT     = 31;
  // Expander count and bus address field
  localparam int          NUM_EXP      = 5;
  localparam int          ADDR_W       = 7;
  localparam int          ADDR_LSB     = 1;
  localparam int          FIELD_STRIDE = 8;
  localparam logic [3:0]  SEL_MAX      = 4'h4;
  // Interrupt status bits
  localparam int          INT_DONE     = 0;
  localparam int          INT_ERR      = 1;
  localparam int          INT_W        = 2;
  // Reset values
  localparam logic [15:0] PIN_RST      = 16'h0000;
  localparam logic [6:0]  ADDR_RST     = 7'h00;
  localparam logic [3:0]  SEL_RST      = 4'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01
  } ioxap_state_type;

  // Selector code names one of the five expanders
  function automatic logic sel_valid(input logic [3:0] s);
    sel_valid = (s <= SEL_MAX);
  endfunction
endpackage

/* verilog/ioxap_arb.sv */
`timescale 1ns/10ps
// Holds pending refresh and initialisation requests, one per expander
module ioxap_arb
  import ioxap_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               arst_n,
  input  wire logic               ce,
  input  wire logic [NUM_EXP-1:0] refresh_set,
  input  wire logic [NUM_EXP-1:0] init_set,
  input  wire logic               take,
  output logic                    grant_valid,
  output logic [2:0]              grant_idx,
  output logic                    grant_init
);
  logic [NUM_EXP-1:0] pend_ref_q;
  logic [NUM_EXP-1:0] pend_init_q;
  logic [NUM_EXP-1:0] clr_ref;
  logic [NUM_EXP-1:0] clr_init;

  // Lowest expander first, initialisation ahead of refresh
  always_comb begin
    grant_valid = 1'b0;
    grant_idx   = 3'h0;
    grant_init  = 1'b0;
    for (int i = NUM_EXP - 1; i >= 0; i--) begin
      if (pend_init_q[i] || pend_ref_q[i]) begin
        grant_valid = 1'b1;
        grant_idx   = 3'(i);
        grant_init  = pend_init_q[i];
      end
    end
  end

  // Only the granted request is retired
  always_comb begin
    clr_ref  = '0;
    clr_init = '0;
    if (take && grant_init) begin
      clr_init[grant_idx] = 1'b1;
    end
    if (take && !grant_init) begin
      clr_ref[grant_idx] = 1'b1;
    end
  end

  // New requests win over retirement of the same bit
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_ref_q  <= '0;
      pend_init_q <= '0;
    end else if (ce) begin
      pend_ref_q  <= (pend_ref_q & ~clr_ref) | refresh_set;
      pend_init_q <= (pend_init_q & ~clr_init) | init_set;
    end
  end
endmodule

/* verilog/ioxap_top.sv */
// The Wishbone register port was decided locally.
`timescale 1ns/10ps
// Operation
// RULE1 - Pin field reads shadow of selected expander
// RULE2 - Pin writes ignored unless test override set
// RULE3 - Test mode sends software pin values out
// RULE4 - Input bits of pin field stay read-only
// RULE5 - Refresh trigger launches SMBus refresh transaction
// RULE6 - Refresh trigger always reads back zero
// RULE7 - Test mode ignores core outputs; write with trigger
// RULE8 - Select codes zero to four; rest reserved
// RULE9 - Done flag W1C, set on selected refresh
// RULE10 - Done also set on test update finish
// RULE11 - Done also set on selected init finish
// RULE12 - Each expander uses its 7-bit address field
// RULE13 - Inputs updated only on successful refresh; code also updates them on a successful init
module ioxap_top
  import ioxap_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      arst_n,
  input  wire logic                      ce,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [11:0]               wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic [NUM_EXP*PIN_W-1:0]  core_out_vals,
  input  wire logic [NUM_EXP*PIN_W-1:0]  out_mask,
  output logic                           smb_req,
  output logic                           smb_init,
  output logic      [2:0]                smb_idx,
  output logic      [ADDR_W-1:0]         smb_addr,
  output logic      [PIN_W-1:0]          smb_wdata,
  input  wire logic                      smb_done,
  input  wire logic                      smb_ok,
  input  wire logic [PIN_W-1:0]          smb_rdata,
  output logic                           irq
);
  logic [PIN_W-1:0]  shadow_q [NUM_EXP];
  logic [ADDR_W-1:0] expaddr_q [NUM_EXP];
  logic              test_q;
  logic [3:0]        sel_q;
  logic              done_q;
  logic [INT_W-1:0]  int_stat_q;
  logic [INT_W-1:0]  int_en_q;
  ioxap_state_type   st_q;
  logic              wr_fire;
  logic              wr_acc;
  logic              wr_test;
  logic [3:0]        wr_sel;
  logic              refresh_req;
  logic [PIN_W-1:0]  wr_pins;
  logic [NUM_EXP-1:0] refresh_set;
  logic [NUM_EXP-1:0] init_set;
  logic              grant_valid;
  logic [2:0]        grant_idx;
  logic              grant_init;
  logic              take;
  logic              finish;
  logic [31:0]       rd_mux;
  logic [PIN_W-1:0]  sh_sel;
  logic [PIN_W-1:0]  mask_sel;
  logic [PIN_W-1:0]  mask_cur;
  logic [PIN_W-1:0]  send_val;

  // Slice helper for the flat per-expander vectors
  function automatic logic [PIN_W-1:0] slice16(input logic [NUM_EXP*PIN_W-1:0] v,
                                               input logic [2:0] i);
    slice16 = v[i*PIN_W +: PIN_W];
  endfunction

  // Bus strobes: a write takes effect on the edge where ack is seen
  assign wr_fire  = ce && wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign wr_acc   = wr_fire && (wb_adr_i == OFS_ACCESS);
  assign wr_sel   = wb_sel_i[3] ? wb_dat_i[SEL_LSB +: SEL_W] : sel_q;
  assign wr_test  = wb_sel_i[3] ? wb_dat_i[TEST_BIT] : test_q;
  assign wr_pins  = {wb_sel_i[1] ? wb_dat_i[15:8] : sh_sel[15:8],
                     wb_sel_i[0] ? wb_dat_i[7:0] : sh_sel[7:0]};
  assign refresh_req = wr_acc && wb_sel_i[3] && wb_dat_i[REFRESH_BIT]
                       && sel_valid(wr_sel);                              // [RULE5] [RULE8]
  assign sh_sel   = sel_valid(sel_q) ? shadow_q[sel_q[2:0]] : PIN_RST;
  assign mask_sel = sel_valid(sel_q) ? slice16(out_mask, sel_q[2:0]) : '0;
  assign mask_cur = slice16(out_mask, smb_idx);
  assign take     = ce && (st_q == ST_IDLE) && grant_valid;
  assign finish   = ce && (st_q == ST_BUSY) && smb_done;

  // Refresh of the selected expander, init of each rewritten address field
  always_comb begin
    refresh_set = '0;
    init_set    = '0;
    if (refresh_req) begin
      refresh_set[wr_sel[2:0]] = 1'b1;
    end
    if (wr_fire && wb_adr_i == OFS_EXPADDR0) begin
      init_set[3:0] = wb_sel_i;                                           // [RULE11]
    end
    if (wr_fire && wb_adr_i == OFS_EXPADDR1) begin
      init_set[4] = wb_sel_i[0];                                          // [RULE11]
    end
  end

  ioxap_arb u_arb (
    .sys_clk     (sys_clk),
    .arst_n      (arst_n),
    .ce          (ce),
    .refresh_set (refresh_set),
    .init_set    (init_set),
    .take        (take),
    .grant_valid (grant_valid),
    .grant_idx   (grant_idx),
    .grant_init  (grant_init)
  );

  // Outputs come from the shadow in test mode, else from the core
  assign send_val = (test_q ? shadow_q[grant_idx] : slice16(core_out_vals, grant_idx))
                    & slice16(out_mask, grant_idx);                       // [RULE3] [RULE7]

  // Transaction sequencer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE;
    end else if (take) begin
      st_q <= ST_BUSY;
    end else if (finish) begin
      st_q <= ST_IDLE;
    end
  end

  // Request held to the SMBus engine until it reports completion
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      smb_req   <= 1'b0;
      smb_init  <= 1'b0;
      smb_idx   <= 3'h0;
      smb_addr  <= ADDR_RST;
      smb_wdata <= PIN_RST;
    end else if (take) begin
      smb_req   <= 1'b1;                                                  // [RULE5]
      smb_init  <= grant_init;
      smb_idx   <= grant_idx;
      smb_addr  <= expaddr_q[grant_idx];                                  // [RULE12]
      smb_wdata <= send_val;
    end else if (finish) begin
      smb_req   <= 1'b0;
    end
  end

  // Control fields of the access register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      test_q <= 1'b0;
      sel_q  <= SEL_RST;
    end else if (wr_acc && wb_sel_i[3]) begin
      test_q <= wb_dat_i[TEST_BIT];
      sel_q  <= wb_dat_i[SEL_LSB +: SEL_W];
    end
  end

  // Completion flag: hardware set wins over write-one-to-clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_q <= 1'b0;
    end else if (finish && {1'b0, smb_idx} == sel_q) begin
      done_q <= 1'b1;                                                     // [RULE9] [RULE10] [RULE11]
    end else if (wr_acc && wb_sel_i[3] && wb_dat_i[DONE_BIT]) begin
      done_q <= 1'b0;                                                     // [RULE9]
    end
  end

  // Pin shadow: test writes touch output bits, successful completions refresh all
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_EXP; i++) begin
        shadow_q[i] <= PIN_RST;
      end
    end else if (ce) begin
      if (wr_acc && wr_test && sel_valid(wr_sel) && wr_sel == sel_q
          && wb_sel_i[1:0] != 2'b00) begin
        shadow_q[sel_q[2:0]] <= (sh_sel & ~mask_sel) | (wr_pins & mask_sel); // [RULE2] [RULE4]
      end
      if (finish && smb_ok) begin
        shadow_q[smb_idx] <= (smb_rdata & ~mask_cur) | (smb_wdata & mask_cur); // [RULE13] [RULE1]
      end
    end
  end

  // Expander bus address fields
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_EXP; i++) begin
        expaddr_q[i] <= ADDR_RST;
      end
    end else if (wr_fire) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_adr_i == OFS_EXPADDR0 && wb_sel_i[i]) begin
          expaddr_q[i] <= wb_dat_i[i*FIELD_STRIDE+ADDR_LSB +: ADDR_W];    // [RULE12]
        end
      end
      if (wb_adr_i == OFS_EXPADDR1 && wb_sel_i[0]) begin
        expaddr_q[4] <= wb_dat_i[ADDR_LSB +: ADDR_W];
      end
    end
  end

  // Interrupt status, enable and irq level
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_stat_q <= '0;
      int_en_q   <= '0;
      irq        <= 1'b0;
    end else if (ce) begin
      int_stat_q <= (int_stat_q & ~((wr_fire && wb_adr_i == OFS_INT_CLR)
                                    ? wb_dat_i[INT_W-1:0] : '0))
                    | {finish && !smb_ok, finish};
      if (wr_fire && wb_adr_i == OFS_INT_EN) begin
        int_en_q <= wb_dat_i[INT_W-1:0];
      end
      irq <= |(int_stat_q & int_en_q);
    end
  end

  // Read mux; trigger bit and reserved bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      OFS_ACCESS: begin
        rd_mux[PIN_W-1:0]          = sh_sel;                              // [RULE1] [RULE8]
        rd_mux[REFRESH_BIT]        = 1'b0;                                // [RULE6]
        rd_mux[TEST_BIT]           = test_q;
        rd_mux[SEL_LSB +: SEL_W]   = sel_q;
        rd_mux[DONE_BIT]           = done_q;
      end
      OFS_EXPADDR0: begin
        for (int i = 0; i < 4; i++) begin
          rd_mux[i*FIELD_STRIDE+ADDR_LSB +: ADDR_W] = expaddr_q[i];
        end
      end
      OFS_EXPADDR1: rd_mux[ADDR_LSB +: ADDR_W] = expaddr_q[4];
      OFS_INT_STAT: rd_mux[INT_W-1:0] = int_stat_q;
      OFS_INT_EN:   rd_mux[INT_W-1:0] = int_en_q;
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // Classic Wishbone slave: ack one cycle after the request, then drop
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= rd_mux;
    end
  end

  // Checks; timing assumes ce held high
  pin_read_a: assert property (@(posedge sys_clk) disable iff (!arst_n || !ce) // [RULE1]
    wb_ack_o && !wb_we_i && wb_adr_i == OFS_ACCESS && sel_valid(sel_q)
    && !$past(finish) && !$past(wr_acc) |-> wb_dat_o[PIN_W-1:0] == sh_sel)
    else $error("pin field read mismatch");
  write_ignored_a: assert property (@(posedge sys_clk) disable iff (!arst_n || !ce) // [RULE2]
    wr_acc && !wr_test && !finish && wr_sel == sel_q |=> $stable(sh_sel))
    else $error("pin write taken outside test mode");
  inputs_ro_a: assert property (@(posedge sys_clk) disable iff (!arst_n || !ce) // [RULE4]
    wr_acc && !finish && wr_sel == sel_q
    |=> (sh_sel & ~mask_sel) == $past(sh_sel & ~mask_sel))
    else $error("input bit changed by write");
  refresh_launch_a: assert property (@(posedge sys_clk) disable iff (!arst_n || !ce) // [RULE5]
    refresh_req && st_q == ST_IDLE && !grant_valid |=> ##1 smb_req)
    else $error("refresh not launched");
  trigger_zero_a: assert property (@(posedge sys_clk) disable iff (!arst_n || !ce) // [RULE6]
    wb_ack_o && wb_adr_i == OFS_ACCESS |-> !wb_dat_o[REFRESH_BIT])
    else $error("refresh bit reads one");
  test_send_a: assert property (@(posedge sys_clk) disable iff (!arst_n || !ce) // [RULE3]
    $rose(smb_req) && $past(test_q)
    |-> smb_wdata == ($past(shadow_q[grant_idx]) & mask_cur))
    else $error("test mode output not from shadow");
  reserved_sel_a: assert property (@(posedge sys_clk) disable iff (!arst_n || !ce) // [RULE8]
    wr_acc && wb_sel_i[3] && wb_dat_i[REFRESH_BIT]
    && !sel_valid(wb_dat_i[SEL_LSB +: SEL_W]) |-> refresh_set == '0)
    else $error("refresh for reserved select");
  reserved_read_a: assert property (@(posedge sys_clk) disable iff (!arst_n || !ce) // [RULE8]
    wb_ack_o && !wb_we_i && wb_adr_i == OFS_ACCESS && !sel_valid(sel_q) && !$past(wr_acc)
    |-> wb_dat_o[PIN_W-1:0] == PIN_RST)
    else $error("reserved select shows pin data");
  done_set_a: assert property (@(posedge sys_clk) disable iff (!arst_n || !ce) // [RULE9]
    finish && {1'b0, smb_idx} == sel_q
    |=> done_q ##1 (done_q || $past(wr_acc && wb_sel_i[3] && wb_dat_i[DONE_BIT])))
    else $error("done flag not set on completion");
  test_done_a: assert property (@(posedge sys_clk) disable iff (!arst_n || !ce) // [RULE10]
    finish && !smb_init && test_q && {1'b0, smb_idx} == sel_q |=> done_q)
    else $error("done flag not set after test update");
  init_done_a: assert property (@(posedge sys_clk) disable iff (!arst_n || !ce) // [RULE11]
    finish && smb_init && {1'b0, smb_idx} == sel_q |=> done_q)
    else $error("done flag not set after init");
  addr_used_a: assert property (@(posedge sys_clk) disable iff (!arst_n || !ce) // [RULE12]
    $rose(smb_req) |-> smb_addr == $past(expaddr_q[grant_idx]))
    else $error("wrong expander address");
  fail_keep_a: assert property (@(posedge sys_clk) disable iff (!arst_n || !ce) // [RULE13]
    finish && !smb_ok |=> (shadow_q[$past(smb_idx)] & ~mask_cur)
                          == $past(shadow_q[smb_idx] & ~mask_cur))
    else $error("inputs changed by failed transaction");
endmodule

/* dv/ioxap_exp_model.sv */
`timescale 1ns/10ps
// Expander chips behind the SMBus engine: one answer per request after a set wait
module ioxap_exp_model
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        smb_req,
  input  wire logic [7:0]  delay,
  input  wire logic        ok,
  input  wire logic [15:0] pins,
  output logic             smb_done,
  output logic             smb_ok,
  output logic [15:0]      smb_rdata
);
  logic [7:0] cnt_q;

  // Count the wait, pulse done once, and show junk outside the answer cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q     <= 8'h00;
      smb_done  <= 1'b0;
      smb_ok    <= 1'b0;
      smb_rdata <= 16'h0000;
    end else begin
      smb_done  <= 1'b0;
      smb_ok    <= ~ok;
      smb_rdata <= ~smb_rdata;
      if (!smb_req || smb_done) begin
        cnt_q <= 8'h00;
      end else if (cnt_q == delay) begin
        smb_done  <= 1'b1;
        smb_ok    <= ok;
        smb_rdata <= pins;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule

/* dv/tb_ioxap_top.sv */
`timescale 1ns/10ps
// Register-side bench for the expander access port
module tb_ioxap_top
  import ioxap_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        ce = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdv;
  logic [79:0] core = {48'h0, 16'h9876, 16'h1234};
  logic [79:0] mask = {48'h0, 16'hf000, 16'h00ff};
  logic [7:0]  delay = 8'h03;
  logic        ok = 1'b1;
  logic [15:0] pins = 16'habcd;
  wire  [31:0] wb_dat;
  wire         wb_ack, smb_req, smb_init, smb_done, smb_ok, irq;
  wire  [2:0]  smb_idx;
  wire  [6:0]  smb_addr;
  wire  [15:0] smb_wdata, smb_rdata;
  int          n_mismatch = 0;
  int          checks_done = 0;

  ioxap_top uut (.sys_clk(sys_clk), .arst_n(arst_n), .ce(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .core_out_vals(core), .out_mask(mask),
    .smb_req(smb_req), .smb_init(smb_init), .smb_idx(smb_idx), .smb_addr(smb_addr),
    .smb_wdata(smb_wdata), .smb_done(smb_done), .smb_ok(smb_ok),
    .smb_rdata(smb_rdata), .irq(irq));
  ioxap_exp_model exp_m (.sys_clk(sys_clk), .arst_n(arst_n), .smb_req(smb_req),
    .delay(delay), .ok(ok), .pins(pins), .smb_done(smb_done), .smb_ok(smb_ok),
    .smb_rdata(smb_rdata));

  always #4 sys_clk = ~sys_clk;

  task automatic give_verdict();
    if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic to_fail(input string what);
    n_mismatch++;
    $display("Error %s wait ran out", what);
    give_verdict();
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [11:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (wb_ack !== 1'b1 && i < 20);
    if (wb_ack !== 1'b1) to_fail("wb ack");
    rdv = wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Follow one engine request and compare what it carries
  task automatic smb_txn(input logic [2:0] idx, input logic init, input logic [6:0] a,
                         input logic chk_wd, input logic [15:0] wd);
    int i;
    for (i = 0; smb_req !== 1'b1; i++) begin
      if (i > 50) to_fail("smb_req rise");
      @(posedge sys_clk);
    end
    check("smb_idx", smb_idx, idx);
    check("smb_init", smb_init, init);
    check("smb_addr", smb_addr, a);
    if (chk_wd) check("smb_wdata", smb_wdata, wd);
    for (i = 0; smb_req !== 1'b0; i++) begin
      if (i > 300) to_fail("smb_req fall");
      @(posedge sys_clk);
    end
    repeat (3) @(posedge sys_clk);
  endtask

  // Bus frozen while ce is low, then reset values and an unmapped read
  task automatic s_reset();
    ce  <= 1'b0;
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= OFS_ACCESS;
    repeat (4) @(posedge sys_clk);
    check("ce freeze ack", wb_ack, 1'b0);
    cyc <= 1'b0;
    stb <= 1'b0;
    ce  <= 1'b1;
    @(posedge sys_clk);
    wb(1'b0, OFS_ACCESS, 4'hf, 32'h0);
    check("access reset", rdv, 32'h0);
    wb(1'b0, 12'h43c, 4'hf, 32'h0);
    check("unmapped read", rdv, 32'h0);
  endtask

  // Address write starts an init whose end sets the flag, then W1C clears it
  task automatic s_init();
    wb(1'b1, OFS_EXPADDR0, 4'h1, 32'h0000_0054);
    smb_txn(3'd0, 1'b1, 7'h2a, 1'b0, 16'h0);
    wb(1'b0, OFS_EXPADDR0, 4'hf, 32'h0);
    check("addr reg", rdv, 32'h0000_0054);
    wb(1'b0, OFS_ACCESS, 4'hf, 32'h0);
    check("done init", rdv & 32'hff00_0000, 32'h8000_0000);
    wb(1'b1, OFS_ACCESS, 4'h8, 32'h8000_0000);
    wb(1'b0, OFS_ACCESS, 4'hf, 32'h0);
    check("done clear", rdv & 32'hff00_0000, 32'h0);
  endtask

  // Refresh of expander 0 with outputs from the core
  task automatic s_refresh();
    wb(1'b1, OFS_ACCESS, 4'h8, 32'h0100_0000);
    smb_txn(3'd0, 1'b0, 7'h2a, 1'b1, 16'h0034);
    wb(1'b0, OFS_ACCESS, 4'hf, 32'h0);
    check("refresh read", rdv, 32'h8000_ab34);
    wb(1'b1, OFS_ACCESS, 4'hf, 32'h8000_5555);
    repeat (10) @(posedge sys_clk);
    check("no launch", smb_req, 1'b0);
    wb(1'b0, OFS_ACCESS, 4'hf, 32'h0);
    check("pin write off", rdv, 32'h0000_ab34);
  endtask

  // Failed refresh keeps inputs; interrupt raised, cleared, then masked
  task automatic s_fail_irq();
    wb(1'b1, OFS_INT_CLR, 4'hf, 32'h3);
    wb(1'b1, OFS_INT_EN, 4'hf, 32'h3);
    check("irq idle", irq, 1'b0);
    ok <= 1'b0;
    pins <= 16'h0000;
    wb(1'b1, OFS_ACCESS, 4'h8, 32'h8100_0000);
    smb_txn(3'd0, 1'b0, 7'h2a, 1'b1, 16'h0034);
    check("irq on", irq, 1'b1);
    wb(1'b0, OFS_ACCESS, 4'hf, 32'h0);
    check("fail keeps", rdv[15:0], 16'hab34);
    wb(1'b0, OFS_INT_STAT, 4'hf, 32'h0);
    check("int stat", rdv, 32'h3);
    wb(1'b1, OFS_INT_CLR, 4'hf, 32'h3);
    wb(1'b1, OFS_INT_EN, 4'hf, 32'h0);
    check("irq cleared", irq, 1'b0);
    ok <= 1'b1;
    wb(1'b1, OFS_ACCESS, 4'h8, 32'h8100_0000);
    smb_txn(3'd0, 1'b0, 7'h2a, 1'b1, 16'h0034);
    check("irq masked", irq, 1'b0);
    wb(1'b0, OFS_INT_STAT, 4'hf, 32'h0);
    check("int stat ok", rdv, 32'h1);
    wb(1'b1, OFS_INT_CLR, 4'hf, 32'h3);
  endtask

  // Test mode: core ignored, software outputs sent, input bits read-only
  task automatic s_test();
    core[15:0] <= 16'hffff;
    pins <= 16'h1100;
    wb(1'b1, OFS_ACCESS, 4'hf, 32'h8300_0f0f);
    smb_txn(3'd0, 1'b0, 7'h2a, 1'b1, 16'h000f);
    wb(1'b0, OFS_ACCESS, 4'hf, 32'h0);
    check("test read", rdv, 32'h8200_110f);
    wb(1'b1, OFS_ACCESS, 4'h3, 32'h0000_ffff);
    wb(1'b0, OFS_ACCESS, 4'hf, 32'h0);
    check("test pin write", rdv, 32'h8200_11ff);
  endtask

  // Another expander, then a reserved select code
  task automatic s_select();
    pins <= 16'h0421;
    wb(1'b1, OFS_ACCESS, 4'hf, 32'h8500_0000);
    smb_txn(3'd1, 1'b0, 7'h00, 1'b1, 16'h9000);
    wb(1'b0, OFS_ACCESS, 4'hf, 32'h0);
    check("sel1 read", rdv, 32'h8400_9421);
    wb(1'b1, OFS_ACCESS, 4'h8, 32'h9500_0000);
    repeat (10) @(posedge sys_clk);
    check("reserved sel", smb_req, 1'b0);
    wb(1'b0, OFS_ACCESS, 4'hf, 32'h0);
    check("reserved pins", rdv[15:0], 16'h0);
    wb(1'b1, OFS_EXPADDR1, 4'h1, 32'h0000_0022);
    smb_txn(3'd4, 1'b1, 7'h11, 1'b0, 16'h0);
    wb(1'b0, OFS_EXPADDR1, 4'hf, 32'h0);
    check("addr reg 4", rdv, 32'h0000_0022);
    wb(1'b0, OFS_ACCESS, 4'hf, 32'h0);
    check("done not sel", rdv[31], 1'b0);
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    s_reset();
    s_init();
    s_refresh();
    s_fail_irq();
    s_test();
    s_select();
    give_verdict();
  end
endmodule
